// file: include/stm_pkg.sv
// package for the smbus temperature monitor control block
package stm_pkg;

  // ----------------------------------------
  // register read and write addresses
  // ----------------------------------------
  localparam logic [7:0] RA_LOCAL_VAL  = 8'h00;
  localparam logic [7:0] RA_REMOTE_VAL = 8'h01;
  localparam logic [7:0] RA_CONFIG     = 8'h03;
  localparam logic [7:0] RA_RATE       = 8'h04;
  localparam logic [7:0] RA_LHI        = 8'h05;
  localparam logic [7:0] RA_LLO        = 8'h06;
  localparam logic [7:0] RA_RHI        = 8'h07;
  localparam logic [7:0] RA_RLO        = 8'h08;
  localparam logic [7:0] WA_CONFIG     = 8'h09;
  localparam logic [7:0] WA_RATE       = 8'h0A;
  localparam logic [7:0] WA_LHI        = 8'h0B;
  localparam logic [7:0] WA_LLO        = 8'h0C;
  localparam logic [7:0] WA_RHI        = 8'h0D;
  localparam logic [7:0] WA_RLO        = 8'h0E;
  localparam logic [7:0] WA_ONE_SHOT   = 8'h0F;

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int          CFG_STANDBY_BIT = 6;
  localparam int          CFG_MASK_BIT    = 7;
  localparam int          RATE_CODE_W     = 3;
  localparam logic [7:0]  CONFIG_RST      = 8'h00;
  localparam logic [7:0]  RATE_RST        = 8'h02;
  localparam logic [7:0]  HI_LIMIT_RST    = 8'h7F;
  localparam logic [7:0]  LO_LIMIT_RST    = 8'hC9;
  localparam logic [7:0]  UNDEF_READ      = 8'hFF;

  // ----------------------------------------
  // addresses chosen by the select pins, tri-level: 0 low, 1 open, 2 high
  // ----------------------------------------
  localparam logic [6:0] ADDR_TABLE [9] = '{7'h18, 7'h19, 7'h1A, 7'h29, 7'h2A, 7'h2B,
                                            7'h4C, 7'h4D, 7'h4E};
  localparam logic [1:0] LVL_LOW  = 2'h0;
  localparam logic [1:0] LVL_OPEN = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;

  // ----------------------------------------
  // timing: fastest conversion period at code 7, slower codes double it
  // ----------------------------------------
  localparam int CLK_HZ        = 20_000_000;
  localparam int CONV_FAST_MS  = 125;
  localparam int CONV_FAST_CYC = (CLK_HZ / 1000) * CONV_FAST_MS;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] ptr;
    logic [7:0] data;
  } stm_reg_req_t;

  typedef struct packed {
    logic lhigh;
    logic llow;
    logic rhigh;
    logic rlow;
  } stm_alarm_t;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRITE, ST_WRITE_ACK,
                            ST_READ, ST_READ_ACK} stm_bus_state_t;

  function automatic logic [6:0] stm_addr_lookup(input logic [1:0] a, input logic [1:0] b);
    logic [3:0] idx;
    idx = 4'(a) * 4'h3 + 4'(b);
    return (idx < 4'h9) ? ADDR_TABLE[idx] : ADDR_TABLE[4];
  endfunction

endpackage

// file: rtl/stm_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module stm_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      meta_q <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // stm_sync
`default_nettype wire

// file: rtl/stm_compare.sv
// limit comparators and conversion timer
`timescale 1ns/1ns
`default_nettype none
module stm_compare
  import stm_pkg::*;
#(
  parameter int FAST_CYC = CONV_FAST_CYC
) (
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire logic                   ce,
  input  wire logic                   run,
  input  wire logic                   one_shot,
  input  wire logic [RATE_CODE_W-1:0] rate_code,
  input  wire logic [7:0]             local_meas,
  input  wire logic [7:0]             remote_meas,
  input  wire logic [7:0]             lhi,
  input  wire logic [7:0]             llo,
  input  wire logic [7:0]             rhi,
  input  wire logic [7:0]             rlo,
  output logic                        conv_done,
  output logic      [7:0]             local_val_q,
  output logic      [7:0]             remote_val_q,
  output stm_alarm_t                  alarm_q
);
  logic [31:0] tick_q;
  logic [31:0] period;
  logic        shot_q;

  // codes above 7 cannot occur; the field is three bits wide
  assign period    = 32'(FAST_CYC) << (3'h7 - rate_code);
  assign conv_done = (run && tick_q >= period - 32'h1) || shot_q;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      tick_q <= '0;
      shot_q <= 1'b0;
    end else if (ce) begin
      shot_q <= one_shot && !run;
      if (!run || conv_done) tick_q <= '0;
      else tick_q <= tick_q + 32'h1;
    end
  end

  // values hold while idle, so standby keeps the last result
  always_ff @(posedge clock) begin
    if (!nrst) begin
      local_val_q  <= 8'h80;
      remote_val_q <= 8'h80;
      alarm_q      <= '0;
    end else if (ce && conv_done) begin
      local_val_q  <= local_meas;
      remote_val_q <= remote_meas;
      alarm_q.lhigh <= $signed(local_meas)  > $signed(lhi);
      alarm_q.llow  <= $signed(local_meas)  < $signed(llo);
      alarm_q.rhigh <= $signed(remote_meas) > $signed(rhi);
      alarm_q.rlow  <= $signed(remote_meas) < $signed(rlo);
    end
  end
endmodule // stm_compare
`default_nettype wire

// file: rtl/stm_control.sv
// smbus slave and control registers of the temperature monitor
//
// Overview of operation
// - config bit 6 selects run or standby
// - low standby pin forces standby
// - results hold their values during standby
// - config bit 7 masks the alert output
// - rate code divides conversion clock by powers
// - rate register readable, upper bits written zero
// - four readable writable limit registers
// - strict greater and less than alarms
// - limits accept negative signed values
// - one-shot write in software standby, pin high, runs one cycle
// - one-shot data byte is discarded
// - address from two tri-level select pins
// - select pins sampled once after reset
// - capture seven address bits and direction
// - acknowledge only a matching address
// - direction zero writes, one reads
// - nine clocks per byte, stop on rise
// - direction fixed until a new start
// - first write byte loads pointer, second stores
// - read returns the pointer-selected register
// - wrong-direction access gives undefined data
// - one-shot decoded at write address 0F
`timescale 1ns/1ns
`default_nettype none
module stm_control
  import stm_pkg::*;
#(
  parameter int FAST_CYC = CONV_FAST_CYC
) (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic       serial_clock_in,
  input  wire logic       serial_data_line_in,
  output logic            serial_data_line_out,
  output logic            serial_data_line_oe,
  input  wire logic       standby_pin_n,
  input  wire logic [1:0] addr_select_pin_a,
  input  wire logic [1:0] addr_select_pin_b,
  input  wire logic [7:0] local_meas,
  input  wire logic [7:0] remote_meas,
  output logic            alert_n_out,
  output logic            alert_n_oe,
  output logic            converting
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic       standby_pin_n_n_s;
  logic [3:0] sel_s;
  logic       scl_q;
  logic       sda_q;

  stm_sync #(.W(1)) u_scl (.clock(clock), .nrst(nrst), .ce(ce),
    .d(serial_clock_in), .q(scl_s[0]));
  stm_sync #(.W(1)) u_sda (.clock(clock), .nrst(nrst), .ce(ce),
    .d(serial_data_line_in), .q(sda_s[0]));
  stm_sync #(.W(1)) u_stb (.clock(clock), .nrst(nrst), .ce(ce),
    .d(standby_pin_n), .q(standby_pin_n_n_s));
  stm_sync #(.W(4)) u_sel (.clock(clock), .nrst(nrst), .ce(ce),
    .d({addr_select_pin_a, addr_select_pin_b}), .q(sel_s));

  always_ff @(posedge clock) begin
    if (!nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce) begin
      scl_q <= scl_s[0];
      sda_q <= sda_s[0];
    end
  end
  assign scl_s[1] = scl_q;
  assign sda_s[1] = sda_q;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise  = scl_s[0] && !scl_q;
  assign scl_fall  = !scl_s[0] && scl_q;
  assign start_det = scl_s[0] && scl_q && sda_q && !sda_s[0];
  // data rise with clock high ends the frame
  assign stop_det  = scl_s[0] && scl_q && !sda_q && sda_s[0];

  // ----------------------------------------
  // slave address, caught once after reset
  // ----------------------------------------
  logic [6:0] own_addr_q;
  logic [1:0] strap_wait_q;
  logic       strap_done_q;

  // sample select pins once, four edges after release
  always_ff @(posedge clock) begin
    if (!nrst) begin
      own_addr_q   <= '0;
      strap_wait_q <= '0;
      strap_done_q <= 1'b0;
    end else if (ce && !strap_done_q) begin
      strap_wait_q <= strap_wait_q + 2'h1;
      if (strap_wait_q == 2'h3) begin
        // tri-level select pins pick the address
        own_addr_q   <= stm_addr_lookup(sel_s[3:2], sel_s[1:0]);
        strap_done_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // serial state machine
  // ----------------------------------------
  stm_bus_state_t state_q;
  logic [7:0]     shift_q;
  logic [3:0]     bit_q;
  logic           rd_dir_q;
  logic           ptr_loaded_q;
  logic           match;
  logic           bus_wr;
  logic [7:0]     ptr_q;
  logic [7:0]     rd_data;

  // seven address bits then direction, msb first
  assign match = shift_q[7:1] == own_addr_q;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_q      <= ST_IDLE;
      shift_q      <= '0;
      bit_q        <= '0;
      rd_dir_q     <= 1'b0;
      ptr_loaded_q <= 1'b0;
    end else if (ce) begin
      if (start_det) begin
        // a new start is the only way to change direction
        state_q      <= ST_ADDR;
        bit_q        <= '0;
        ptr_loaded_q <= 1'b0;
      end else if (stop_det) begin
        state_q <= ST_IDLE;
      end else begin
        case (state_q)
          ST_ADDR, ST_WRITE: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_s[0]};
              bit_q   <= bit_q + 4'h1;
            end else if (scl_fall && bit_q == 4'h8) begin
              bit_q <= '0;
              if (state_q == ST_WRITE) begin
                state_q      <= ST_WRITE_ACK;
                ptr_loaded_q <= 1'b1;
              end else if (match) begin
                state_q  <= ST_ADDR_ACK;
                // direction bit picks write or read
                rd_dir_q <= shift_q[0];
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) state_q <= rd_dir_q ? ST_READ : ST_WRITE;
          end
          ST_WRITE_ACK: begin
            if (scl_fall) state_q <= ST_WRITE;
          end
          ST_READ: begin
            if (scl_rise) bit_q <= bit_q + 4'h1;
            else if (scl_fall && bit_q == 4'h8) begin
              bit_q   <= '0;
              state_q <= ST_READ_ACK;
            end
          end
          ST_READ_ACK: begin
            // a not-acknowledge releases the bus until the next start
            if (scl_rise) state_q <= sda_s[0] ? ST_IDLE : ST_READ_ACK;
            else if (scl_fall) state_q <= ST_READ;
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // write byte completes on the falling edge that opens its ack
  assign bus_wr = ce && scl_fall && state_q == ST_WRITE && bit_q == 4'h8;

  // pointer only changes on the first byte of a write
  always_ff @(posedge clock) begin
    if (!nrst) ptr_q <= '0;
    // first data byte loads the pointer
    else if (bus_wr && !ptr_loaded_q) ptr_q <= shift_q;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] cfg_q;
  logic [7:0] rate_q;
  logic [7:0] lhi_q;
  logic [7:0] llo_q;
  logic [7:0] rhi_q;
  logic [7:0] rlo_q;
  logic       reg_wr;
  logic       one_shot;

  assign reg_wr   = bus_wr && ptr_loaded_q;
  // one-shot decoded at its write address
  assign one_shot = reg_wr && ptr_q == WA_ONE_SHOT;

  // one-shot data is never stored anywhere
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cfg_q  <= CONFIG_RST;
      rate_q <= RATE_RST;
      lhi_q  <= HI_LIMIT_RST;
      llo_q  <= LO_LIMIT_RST;
      rhi_q  <= HI_LIMIT_RST;
      rlo_q  <= LO_LIMIT_RST;
    end else if (reg_wr) begin
      case (ptr_q)
        WA_CONFIG: cfg_q  <= shift_q;
        // rate stored whole; master keeps upper bits zero
        WA_RATE:   rate_q <= shift_q;
        WA_LHI:    lhi_q  <= shift_q;
        WA_LLO:    llo_q  <= shift_q;
        WA_RHI:    rhi_q  <= shift_q;
        WA_RLO:    rlo_q  <= shift_q;
        default:   ;
      endcase
    end
  end

  // ----------------------------------------
  // conversion control
  // ----------------------------------------
  logic       run;
  logic       conv_done;
  logic [7:0] local_val;
  logic [7:0] remote_val;
  stm_alarm_t alarm;
  logic       shot_pend_q;

  assign run = !cfg_q[CFG_STANDBY_BIT] && standby_pin_n_n_s;

  // one-shot only while software standby, pin high
  always_ff @(posedge clock) begin
    if (!nrst) shot_pend_q <= 1'b0;
    else if (ce) shot_pend_q <= one_shot && !run && standby_pin_n_n_s;
  end

  // results hold in the comparator while idle
  // rate code sets the conversion period
  stm_compare #(.FAST_CYC(FAST_CYC)) u_cmp (
    .clock       (clock),
    .nrst        (nrst),
    .ce          (ce),
    .run         (run),
    .one_shot    (shot_pend_q),
    .rate_code   (rate_q[RATE_CODE_W-1:0]),
    .local_meas  (local_meas),
    .remote_meas (remote_meas),
    .lhi         (lhi_q),
    .llo         (llo_q),
    .rhi         (rhi_q),
    .rlo         (rlo_q),
    .conv_done   (conv_done),
    .local_val_q (local_val),
    .remote_val_q(remote_val),
    .alarm_q     (alarm)
  );
  assign converting = conv_done;

  assign alert_n_out = 1'b0;
  assign alert_n_oe  = (|alarm) && !cfg_q[CFG_MASK_BIT];

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // read returns the register at the pointer
  // write-only or unknown addresses read undefined
  always_comb begin
    case (ptr_q)
      RA_LOCAL_VAL:  rd_data = local_val;
      RA_REMOTE_VAL: rd_data = remote_val;
      RA_CONFIG:     rd_data = cfg_q;
      RA_RATE:       rd_data = rate_q;
      RA_LHI:        rd_data = lhi_q;
      RA_LLO:        rd_data = llo_q;
      RA_RHI:        rd_data = rhi_q;
      RA_RLO:        rd_data = rlo_q;
      default:       rd_data = UNDEF_READ;
    endcase
  end

  logic sda_oe_q;
  always_ff @(posedge clock) begin
    if (!nrst) sda_oe_q <= 1'b0;
    else if (ce && scl_fall) begin
      if (state_q == ST_ADDR && bit_q == 4'h8) sda_oe_q <= match;
      else if (state_q == ST_WRITE && bit_q == 4'h8) sda_oe_q <= 1'b1;
      else if ((state_q == ST_ADDR_ACK && rd_dir_q) || (state_q == ST_READ && bit_q != 4'h8)
               || state_q == ST_READ_ACK)
        sda_oe_q <= !rd_data[3'h7 - 3'(state_q == ST_READ ? bit_q : 4'h0)];
      else sda_oe_q <= 1'b0;
    end else if (ce && stop_det) sda_oe_q <= 1'b0;
  end
  assign serial_data_line_out = 1'b0;
  assign serial_data_line_oe  = sda_oe_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_standby_pin_halts: assert property (@(posedge clock) disable iff (!nrst)
    (!standby_pin_n_n_s && !$past(standby_pin_n_n_s) && !$past(standby_pin_n_n_s, 2)) |-> !conv_done)
    else $error("standby pin did not stop conversions");
  a_alert_mask_gate: assert property (@(posedge clock) disable iff (!nrst)
    cfg_q[CFG_MASK_BIT] |-> !alert_n_oe) else $error("alert driven while masked");
  a_ptr_holds_read: assert property (@(posedge clock) disable iff (!nrst)
    !bus_wr |=> $stable(ptr_q)) else $error("pointer changed without a write");
  a_one_shot_fires: assert property (@(posedge clock) disable iff (!nrst)
    (one_shot && !run && standby_pin_n_n_s) |-> ##2 conv_done) else $error("one-shot did not convert");
  a_no_shot_store: assert property (@(posedge clock) disable iff (!nrst)
    one_shot |=> $stable(cfg_q) && $stable(rate_q)) else $error("one-shot data stored");
  a_standby_holds: assert property (@(posedge clock) disable iff (!nrst)
    (!run && !conv_done) |=> $stable(local_val)) else $error("value changed in standby");
  a_addr_fixed: assert property (@(posedge clock) disable iff (!nrst)
    strap_done_q |=> $stable(own_addr_q)) else $error("slave address changed");
  a_stop_idles: assert property (@(posedge clock) disable iff (!nrst)
    (ce && stop_det && !start_det) |=> state_q == ST_IDLE) else $error("stop not seen");
endmodule // stm_control
`default_nettype wire

// file: tb/stm_master.sv
// smbus master model that drives the serial clock and pulls the data line
`timescale 1ns/1ns
`default_nettype none
module stm_master #(
  parameter int HALF = 8
) (
  input  wire logic clock,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe
);
  // the clock only moves inside a frame; between frames both lines rest high
  initial begin
    scl    = 1'b1;
    sda_oe = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // data set while the clock is low, sampled at the end of the high time
  task automatic bit_io(input logic b, output logic seen);
    sda_oe <= ~b;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    seen = sda;
    scl <= 1'b0;
    tick(1);
  endtask

  task automatic start_c();
    sda_oe <= 1'b1;
    tick(HALF);
    scl <= 1'b0;
    tick(HALF);
  endtask

  // data low while the clock is low, released during the next high clock
  task automatic stop_c();
    sda_oe <= 1'b1;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sda_oe <= 1'b0;
    tick(2 * HALF);
  endtask

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // the master ends every read byte with a not-acknowledge
  task automatic get_byte(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(1'b1, s);
  endtask

  // ----------------------------------------
  // whole operations
  // ----------------------------------------
  // direction zero, pointer byte, optional data byte, stop
  task automatic write_op(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                          input logic two, output logic ack);
    logic k;
    start_c();
    put_byte({a, 1'b0}, ack);
    if (ack) begin
      put_byte(p, k);
      if (two) put_byte(d, k);
    end
    stop_c();
  endtask

  // direction one, a single byte, then stop
  task automatic read_op(input logic [6:0] a, output logic [7:0] d, output logic ack);
    start_c();
    put_byte({a, 1'b1}, ack);
    d = 8'hFF;
    if (ack) get_byte(d);
    stop_c();
  endtask
endmodule // stm_master
`default_nettype wire

// file: tb/smbus_temp_monitor_control_tb_top.sv
// self-checking bench for the smbus temperature monitor control block
`timescale 1ns/1ns
`default_nettype none
module smbus_temp_monitor_control_tb_top;
  import stm_pkg::*;
  localparam int FAST  = 16;
  localparam int LIMIT = 60000;
  logic       clock         = 1'b0;
  logic       nrst          = 1'b0;
  logic       standby_pin_n = 1'b1;
  logic [1:0] sel_a         = 2'h0;
  logic [1:0] sel_b         = 2'h0;
  logic [7:0] local_meas    = 8'h00;
  logic [7:0] remote_meas   = 8'h00;
  logic       sdl_out;
  logic       sdl_oe;
  logic       alert_n_out;
  logic       alert_n_oe;
  logic       converting;
  logic       scl;
  logic       m_oe;
  wire logic  sda;
  logic [6:0] dev;
  int         n_fail        = 0;
  int         cmp_count     = 0;
  int         cyc           = 0;
  int         conv_n        = 0;

  // pull-up: the line is high unless some party pulls it low
  assign sda = ~(m_oe | sdl_oe);
  always #25 clock = ~clock;

  stm_control #(.FAST_CYC(FAST)) uut (
    .clock(clock), .nrst(nrst), .ce(1'b1), .serial_clock_in(scl), .serial_data_line_in(sda),
    .serial_data_line_out(sdl_out), .serial_data_line_oe(sdl_oe),
    .standby_pin_n(standby_pin_n), .addr_select_pin_a(sel_a), .addr_select_pin_b(sel_b),
    .local_meas(local_meas), .remote_meas(remote_meas), .alert_n_out(alert_n_out),
    .alert_n_oe(alert_n_oe), .converting(converting));
  stm_master #(.HALF(8)) m (.clock(clock), .sda(sda), .scl(scl), .sda_oe(m_oe));

  function automatic logic [6:0] addr_of(input int a, input int b);
    logic [6:0] t [9];
    t = '{7'h18, 7'h19, 7'h1A, 7'h29, 7'h2A, 7'h2B, 7'h4C, 7'h4D, 7'h4E};
    return t[a * 3 + b];
  endfunction

  function automatic logic alarm_of(input logic [7:0] lm, input logic [7:0] rm,
                                    input logic [7:0] hi, input logic [7:0] lo);
    return $signed(lm) > $signed(hi) || $signed(lm) < $signed(lo) ||
           $signed(rm) > $signed(hi) || $signed(rm) < $signed(lo);
  endfunction

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic do_reset(input logic [1:0] a, input logic [1:0] b);
    sel_a <= a;
    sel_b <= b;
    nrst  <= 1'b0;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    repeat (10) @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic k;
    m.write_op(dev, p, d, 1'b1, k);
  endtask

  task automatic rdr(input logic [7:0] p, output logic [7:0] d);
    logic k;
    m.write_op(dev, p, 8'h00, 1'b0, k);
    m.read_op(dev, d, k);
  endtask

  // bounded wait for n result pulses
  task automatic wait_conv(input int n);
    int c0;
    c0 = conv_n;
    for (int i = 0; i < 400 && conv_n < c0 + n; i++) @(posedge clock);
    repeat (3) @(posedge clock);
  endtask

  // ----------------------------------------
  // cycle limit and result counting
  // ----------------------------------------
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (converting === 1'b1) conv_n <= conv_n + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      complete_run();
    end
  end

  initial begin
    logic [7:0] d;
    logic [7:0] v;
    logic       ack;
    int         c0;
    logic [7:0] rd_a [6];
    logic [7:0] rd_v [6];
    logic [7:0] wa   [5];
    logic [7:0] meas [4];
    void'($urandom(32'h949A067F));
    for (int i = 0; i < 9; i++) begin
      do_reset(2'(i / 3), 2'(i % 3));
      dev = addr_of(i / 3, i % 3);
      // pins move after the power-up sample
      sel_a <= 2'(2 - i / 3);
      sel_b <= 2'(i % 3 == 0 ? 2 : 0);
      m.read_op(dev ^ 7'h01, d, ack);
      chk("foreign ack", 8'h00, {7'h00, ack});
      m.read_op(dev, d, ack);
      chk("own ack", 8'h01, {7'h00, ack});
    end
    rd_a = '{RA_CONFIG, RA_RATE, RA_LHI, RA_LLO, RA_RHI, RA_RLO};
    rd_v = '{8'h00, 8'h02, 8'h7F, 8'hC9, 8'h7F, 8'hC9};
    wa   = '{WA_RATE, WA_LHI, WA_LLO, WA_RHI, WA_RLO};
    for (int i = 0; i < 6; i++) begin
      rdr(rd_a[i], d);
      chk("reset value", rd_v[i], d);
    end
    for (int i = 0; i < 5; i++) begin
      v = 8'($urandom);
      if (i == 0) v = {5'h00, v[2:0]};
      else if (i % 2 == 0) v[7] = 1'b1;
      wr(wa[i], v);
      rdr(rd_a[i + 1], d);
      chk("written value", v, d);
      m.read_op(dev, d, ack);
      chk("repeat read", v, d);
    end
    rdr(WA_RATE, d);
    chk("write address read", UNDEF_READ, d);
    wr(WA_RATE, 8'h07);
    for (int i = 1; i < 5; i++) wr(wa[i], i % 2 ? 8'h20 : 8'hF6);
    meas = '{8'h20, 8'h21, 8'hF6, 8'hF5};
    for (int i = 0; i < 8; i++) begin
      local_meas  <= i < 4 ? meas[i % 4] : 8'h00;
      remote_meas <= i < 4 ? 8'h00 : meas[i % 4];
      wait_conv(2);
      chk("alert", {7'h00, alarm_of(local_meas, remote_meas, 8'h20, 8'hF6)}, {7'h00, alert_n_oe});
    end
    wr(WA_CONFIG, 8'h80);
    wait_conv(2);
    chk("masked alert", 8'h00, {7'h00, alert_n_oe});
    wr(WA_CONFIG, 8'h00);
    wait_conv(2);
    chk("unmasked alert", 8'h01, {7'h00, alert_n_oe});
    local_meas  <= 8'h11;
    remote_meas <= 8'h22;
    wait_conv(2);
    wr(WA_CONFIG, 8'h40);
    local_meas  <= 8'h33;
    remote_meas <= 8'h44;
    c0 = conv_n;
    repeat (200) @(posedge clock);
    chk("standby conversions", 8'h00, 8'(conv_n - c0));
    rdr(RA_LOCAL_VAL, d);
    chk("held local", 8'h11, d);
    rdr(RA_REMOTE_VAL, d);
    chk("held remote", 8'h22, d);
    c0 = conv_n;
    wr(WA_ONE_SHOT, 8'($urandom));
    repeat (100) @(posedge clock);
    chk("one-shot conversions", 8'h01, 8'(conv_n - c0));
    rdr(RA_LOCAL_VAL, d);
    chk("one-shot local", 8'h33, d);
    rdr(RA_CONFIG, d);
    chk("config after one-shot", 8'h40, d);
    standby_pin_n <= 1'b0;
    wr(WA_CONFIG, 8'h00);
    c0 = conv_n;
    repeat (200) @(posedge clock);
    chk("pin standby conversions", 8'h00, 8'(conv_n - c0));
    standby_pin_n <= 1'b1;
    c0 = conv_n;
    wait_conv(1);
    chk("run resumed", 8'h01, 8'(conv_n > c0));
    chk("driven levels", 8'h00, {6'h00, sdl_out, alert_n_out});
    complete_run();
  end
endmodule // smbus_temp_monitor_control_tb_top
`default_nettype wire
